// >>> ppf_pkg.sv
package ppf_pkg;

  // register byte offsets
  localparam logic [5:0] OFS_SUP_LOW  = 6'h00;
  localparam logic [5:0] OFS_SUP_HIGH = 6'h04;
  localparam logic [5:0] OFS_DRV_AB   = 6'h08;
  localparam logic [5:0] OFS_DRV_CD   = 6'h0C;
  localparam logic [5:0] OFS_FN_LOW   = 6'h10;
  localparam logic [5:0] OFS_FN_HIGH  = 6'h14;
  localparam logic [5:0] OFS_PA_DATA  = 6'h18;
  localparam logic [5:0] OFS_PA_DIR   = 6'h1C;
  localparam logic [5:0] OFS_PA_PINS  = 6'h20;

  // values after reset
  localparam logic [7:0] RST_CFG = 8'h00;
  localparam logic [7:0] RST_DIR = 8'hFF;

  // implemented bits of the upper supply register
  localparam logic [7:0] SUP_HIGH_MASK = 8'h3F;

  // 2-bit field positions
  localparam int POS_F0 = 0;
  localparam int POS_F1 = 2;
  localparam int POS_F2 = 4;
  localparam int POS_F3 = 6;

  // function / level codes
  localparam logic [1:0] SEL_A = 2'h0;
  localparam logic [1:0] SEL_B = 2'h1;
  localparam logic [1:0] SEL_C = 2'h2;
  localparam logic [1:0] SEL_D = 2'h3;

  // bus answer latency in cycles from request to ack
  localparam int BUS_ACK_CYCLES = 1;

endpackage

// >>> ppf_port_pin_function_config.sv
// Notes on behaviour
// - low supply register: PA6,PA3,PA2,PA0 fields; upper bit 1 picks aux supply
// - high supply register: PC5,PC4,PA7 fields, same encoding
// - bits 7 and 6 of high supply register read as zero
// - aux supply only when PB4 is aux input and field upper bit set
// - drive level acts only on pins driven as CMOS outputs
// - drive codes 00 to 11 are levels 0 (min) to 3 (max)
// - drive ab register: PB7-4, PB3-0, PA7-4, PA3-0 from top down
// - drive cd register: PD6-4, PD3-0, PC7-4, PC3-0 from top down
// - PA3: gpio/ext_interrupt_zero/capture, serial data out, uart0 tx, analog 3
// - PA2: gpio, serial data in, uart0 rx/tx, periodic timer2 inverted
// - PA1: gpio/ext_interrupt_one, chip select, opamp1 output, opamp1 positive input
// - PA0: gpio, serial clock, periodic timer1 inverted, gpio
// - PA7: gpio/captures, serial clock, analog 1, reference voltage
// - PA6: gpio, periodic timer0 out, serial data in, uart0 rx/tx
// - PA5: gpio/timer0 clock, std timer1 inverted, opamp1 output, gpio/timer0 clock
// - PA4: gpio/ptimer0 clock, std timer0 inverted, analog 0, opamp0
// - direction bit 0 is output, 1 is input; resets to 1
//
// Chosen here: the register addresses and the Avalon-MM register port.
`timescale 1ns/10ps
module ppf_port_pin_function_config
  import ppf_pkg::*;
#(
  parameter int ADDR_W = 6
) (
  input  wire logic              clk,
  input  wire logic              rst,
  input  wire logic [ADDR_W-1:0] avs_address,
  input  wire logic              avs_read,
  input  wire logic              avs_write,
  input  wire logic [31:0]       avs_writedata,
  input  wire logic [3:0]        avs_byteenable,
  output logic      [31:0]       avs_readdata,
  output logic                   avs_waitrequest,
  input  wire logic [7:0]        pa_pad_in,
  output logic      [7:0]        pa_pad_out,
  output logic      [7:0]        pa_pad_oe_n,
  output logic      [7:0]        pa_analog_en,
  input  wire logic [7:0]        pb_dir,
  input  wire logic [7:0]        pc_dir,
  input  wire logic [6:0]        pd_dir,
  input  wire logic              pb4_aux_supply_fn,
  output logic      [6:0]        aux_supply_sel,
  output logic      [15:0]       pa_drive_level,
  output logic      [15:0]       pb_drive_level,
  output logic      [15:0]       pc_drive_level,
  output logic      [13:0]       pd_drive_level,
  input  wire logic              serial_clock_out,
  input  wire logic              serial_clock_oe_n,
  input  wire logic              serial_chip_select_out,
  input  wire logic              serial_chip_select_oe_n,
  input  wire logic              serial_data_io_out,
  input  wire logic              serial_data_io_oe_n,
  input  wire logic              serial_data_out,
  input  wire logic              serial_data_out_oe_n,
  input  wire logic              uart0_transmit,
  input  wire logic              uart0_receive_transmit,
  input  wire logic              uart0_rt_oe_n,
  input  wire logic              periodic_timer0_out,
  input  wire logic              periodic_timer1_inverted_out,
  input  wire logic              periodic_timer2_inverted_out,
  input  wire logic              std_timer0_inverted_out,
  input  wire logic              std_timer1_inverted_out,
  output logic                   ext_interrupt_zero,
  output logic                   ext_interrupt_one,
  output logic                   std_timer1_capture_in,
  output logic                   std_timer0_capture_in,
  output logic                   periodic_timer0_capture_in,
  output logic                   std_timer0_clock_in,
  output logic                   periodic_timer0_clock_in,
  output logic                   serial_clock_in,
  output logic                   serial_data_in,
  output logic                   serial_chip_select_in,
  output logic                   uart0_receive_in
);

  // refuse address widths that cannot reach every register
  if (ADDR_W < 6) begin : g_chk
    $error("ADDR_W must be at least 6");
  end

  // two-bit field of a register
  function automatic logic [1:0] fld(input logic [7:0] r, input int pos);
    return r[pos +: 2];
  endfunction

  // drive code applies only while the pin drives as CMOS output
  function automatic logic [1:0] lvl(input logic oe_n,
                                     input logic [1:0] code);
    return oe_n ? SEL_A : code;
  endfunction

  logic [7:0] sup_low;
  logic [7:0] sup_high;
  logic [7:0] drv_ab;
  logic [7:0] drv_cd;
  logic [7:0] fn_low;
  logic [7:0] fn_high;
  logic [7:0] pa_data;
  logic [7:0] pa_dir;
  logic [7:0] pa_meta;
  logic [7:0] pa_sync;
  logic       ack;
  logic       hit;
  logic [5:0] ofs;
  logic       wr_en;
  logic [7:0] wb;
  logic [7:0] next_rd;
  logic [7:0] next_out;
  logic [7:0] next_oe_n;
  logic [7:0] next_ana;
  logic [7:0] gin;

  // bus: one wait cycle, then ack; upper address bits must be zero
  assign ofs   = avs_address[5:0];
  assign hit   = (avs_address >> 6) == '0;
  assign wr_en = avs_write && ack && hit && avs_byteenable[0];
  assign wb    = avs_writedata[7:0];
  assign avs_waitrequest = (avs_read || avs_write) && !ack;

  // ack pulses once per held request so back-to-back requests work
  always_ff @(posedge clk) begin
    if (rst) begin
      ack <= 1'b0;
    end else begin
      ack <= (avs_read || avs_write) && !ack;
    end
  end

  // configuration registers, cleared at reset
  always_ff @(posedge clk) begin
    if (rst) begin
      sup_low  <= RST_CFG;
      sup_high <= RST_CFG;
      drv_ab   <= RST_CFG;
      drv_cd   <= RST_CFG;
      fn_low   <= RST_CFG;
      fn_high  <= RST_CFG;
    end else if (wr_en) begin
      if (ofs == OFS_SUP_LOW) begin
        sup_low <= wb;
      end else if (ofs == OFS_SUP_HIGH) begin
        sup_high <= wb & SUP_HIGH_MASK;
      end else if (ofs == OFS_DRV_AB) begin
        drv_ab <= wb;
      end else if (ofs == OFS_DRV_CD) begin
        drv_cd <= wb;
      end else if (ofs == OFS_FN_LOW) begin
        fn_low <= wb;
      end else if (ofs == OFS_FN_HIGH) begin
        fn_high <= wb;
      end
    end
  end

  // port A latch and direction; pins start as inputs
  always_ff @(posedge clk) begin
    if (rst) begin
      pa_data <= RST_CFG;
      pa_dir  <= RST_DIR;
    end else if (wr_en) begin
      if (ofs == OFS_PA_DATA) begin
        pa_data <= wb;
      end else if (ofs == OFS_PA_DIR) begin
        pa_dir <= wb;
      end
    end
  end

  // read mux; unmapped addresses read zero
  always_comb begin
    next_rd = 8'h00;
    if (!hit) begin
      next_rd = 8'h00;
    end else if (ofs == OFS_SUP_LOW) begin
      next_rd = sup_low;
    end else if (ofs == OFS_SUP_HIGH) begin
      next_rd = sup_high & SUP_HIGH_MASK;
    end else if (ofs == OFS_DRV_AB) begin
      next_rd = drv_ab;
    end else if (ofs == OFS_DRV_CD) begin
      next_rd = drv_cd;
    end else if (ofs == OFS_FN_LOW) begin
      next_rd = fn_low;
    end else if (ofs == OFS_FN_HIGH) begin
      next_rd = fn_high;
    end else if (ofs == OFS_PA_DATA) begin
      next_rd = pa_data;
    end else if (ofs == OFS_PA_DIR) begin
      next_rd = pa_dir;
    end else if (ofs == OFS_PA_PINS) begin
      next_rd = pa_sync;
    end
  end

  // read data captured on the first request cycle, held until next read
  always_ff @(posedge clk) begin
    if (rst) begin
      avs_readdata <= 32'h0000_0000;
    end else if (avs_read && !ack) begin
      avs_readdata <= {24'h00_0000, next_rd};
    end
  end

  // pad inputs come from outside the clock domain
  always_ff @(posedge clk) begin
    if (rst) begin
      pa_meta <= 8'h00;
      pa_sync <= 8'h00;
    end else begin
      pa_meta <= pa_pad_in;
      pa_sync <= pa_meta;
    end
  end

  // port A output mux; default is latch plus direction bit
  always_comb begin
    next_out  = pa_data;
    next_oe_n = pa_dir;
    next_ana  = 8'h00;
    case (fld(fn_low, POS_F0))
      SEL_B: begin
        next_out[0]  = serial_clock_out;
        next_oe_n[0] = serial_clock_oe_n;
      end
      SEL_C: begin
        next_out[0]  = periodic_timer1_inverted_out;
        next_oe_n[0] = 1'b0;
      end
      default: ;
    endcase
    case (fld(fn_low, POS_F1))
      SEL_B: begin
        next_out[1]  = serial_chip_select_out;
        next_oe_n[1] = serial_chip_select_oe_n;
      end
      SEL_C, SEL_D: begin
        next_oe_n[1] = 1'b1;
        next_ana[1]  = 1'b1;
      end
      default: ;
    endcase
    case (fld(fn_low, POS_F2))
      SEL_B: begin
        next_out[2]  = serial_data_io_out;
        next_oe_n[2] = serial_data_io_oe_n;
      end
      SEL_C: begin
        next_out[2]  = uart0_receive_transmit;
        next_oe_n[2] = uart0_rt_oe_n;
      end
      SEL_D: begin
        next_out[2]  = periodic_timer2_inverted_out;
        next_oe_n[2] = 1'b0;
      end
      default: ;
    endcase
    case (fld(fn_low, POS_F3))
      SEL_B: begin
        next_out[3]  = serial_data_out;
        next_oe_n[3] = serial_data_out_oe_n;
      end
      SEL_C: begin
        next_out[3]  = uart0_transmit;
        next_oe_n[3] = 1'b0;
      end
      SEL_D: begin
        next_oe_n[3] = 1'b1;
        next_ana[3]  = 1'b1;
      end
      default: ;
    endcase
    case (fld(fn_high, POS_F0))
      SEL_B: begin
        next_out[4]  = std_timer0_inverted_out;
        next_oe_n[4] = 1'b0;
      end
      SEL_C, SEL_D: begin
        next_oe_n[4] = 1'b1;
        next_ana[4]  = 1'b1;
      end
      default: ;
    endcase
    case (fld(fn_high, POS_F1))
      SEL_B: begin
        next_out[5]  = std_timer1_inverted_out;
        next_oe_n[5] = 1'b0;
      end
      SEL_C: begin
        next_oe_n[5] = 1'b1;
        next_ana[5]  = 1'b1;
      end
      default: ;
    endcase
    case (fld(fn_high, POS_F2))
      SEL_B: begin
        next_out[6]  = periodic_timer0_out;
        next_oe_n[6] = 1'b0;
      end
      SEL_C: begin
        next_out[6]  = serial_data_io_out;
        next_oe_n[6] = serial_data_io_oe_n;
      end
      SEL_D: begin
        next_out[6]  = uart0_receive_transmit;
        next_oe_n[6] = uart0_rt_oe_n;
      end
      default: ;
    endcase
    case (fld(fn_high, POS_F3))
      SEL_B: begin
        next_out[7]  = serial_clock_out;
        next_oe_n[7] = serial_clock_oe_n;
      end
      SEL_C, SEL_D: begin
        next_oe_n[7] = 1'b1;
        next_ana[7]  = 1'b1;
      end
      default: ;
    endcase
  end

  // registered pad drive; costs one cycle but keeps pads glitch free
  always_ff @(posedge clk) begin
    if (rst) begin
      pa_pad_out   <= 8'h00;
      pa_pad_oe_n  <= RST_DIR;
      pa_analog_en <= 8'h00;
    end else begin
      pa_pad_out   <= next_out;
      pa_pad_oe_n  <= next_oe_n;
      pa_analog_en <= next_ana;
    end
  end

  // drive levels per pin, zero unless driving as output
  always_ff @(posedge clk) begin
    if (rst) begin
      pa_drive_level <= 16'h0000;
      pb_drive_level <= 16'h0000;
      pc_drive_level <= 16'h0000;
      pd_drive_level <= 14'h0000;
    end else begin
      for (int i = 0; i < 8; i++) begin
        pa_drive_level[2*i +: 2] <= lvl(next_oe_n[i],
          fld(drv_ab, (i < 4) ? POS_F0 : POS_F1));
        pb_drive_level[2*i +: 2] <= lvl(pb_dir[i],
          fld(drv_ab, (i < 4) ? POS_F2 : POS_F3));
        pc_drive_level[2*i +: 2] <= lvl(pc_dir[i],
          fld(drv_cd, (i < 4) ? POS_F0 : POS_F1));
      end
      for (int i = 0; i < 7; i++) begin
        pd_drive_level[2*i +: 2] <= lvl(pd_dir[i],
          fld(drv_cd, (i < 4) ? POS_F2 : POS_F3));
      end
    end
  end

  // aux rail needs both the PB4 input function and the field's upper bit
  always_ff @(posedge clk) begin
    if (rst) begin
      aux_supply_sel <= 7'h00;
    end else begin
      aux_supply_sel <= {sup_high[POS_F2+1], sup_high[POS_F1+1],
                         sup_high[POS_F0+1], sup_low[POS_F3+1],
                         sup_low[POS_F2+1], sup_low[POS_F1+1],
                         sup_low[POS_F0+1]}
                        & {7{pb4_aux_supply_fn}};
    end
  end

  // shared digital inputs only pass when the pin is set as input
  assign gin = pa_sync & pa_dir;

  // inputs to peripherals; idle level 0 for timers, 1 for serial lines
  always_ff @(posedge clk) begin
    if (rst) begin
      ext_interrupt_zero         <= 1'b0;
      ext_interrupt_one          <= 1'b0;
      std_timer1_capture_in      <= 1'b0;
      std_timer0_capture_in      <= 1'b0;
      periodic_timer0_capture_in <= 1'b0;
      std_timer0_clock_in        <= 1'b0;
      periodic_timer0_clock_in   <= 1'b0;
      serial_clock_in            <= 1'b1;
      serial_data_in             <= 1'b1;
      serial_chip_select_in      <= 1'b1;
      uart0_receive_in           <= 1'b1;
    end else begin
      ext_interrupt_zero    <= fld(fn_low, POS_F3) == SEL_A && gin[3];
      std_timer1_capture_in <= fld(fn_low, POS_F3) == SEL_A && gin[3];
      ext_interrupt_one     <= fld(fn_low, POS_F1) == SEL_A && gin[1];
      std_timer0_capture_in <= fld(fn_high, POS_F3) == SEL_A && gin[7];
      periodic_timer0_capture_in <=
        fld(fn_high, POS_F3) == SEL_A && gin[7];
      std_timer0_clock_in   <= fld(fn_high, POS_F1) inside {SEL_A, SEL_D}
                               && gin[5];
      periodic_timer0_clock_in <=
        fld(fn_high, POS_F0) == SEL_A && gin[4];
      // PA0 wins over PA7 when both carry the serial clock
      serial_clock_in <= (fld(fn_low, POS_F0) == SEL_B) ? pa_sync[0] :
                         (fld(fn_high, POS_F3) == SEL_B) ? pa_sync[7] :
                         1'b1;
      serial_data_in  <= (fld(fn_low, POS_F2) == SEL_B) ? pa_sync[2] :
                         (fld(fn_high, POS_F2) == SEL_C) ? pa_sync[6] :
                         1'b1;
      uart0_receive_in <= (fld(fn_low, POS_F2) == SEL_C) ? pa_sync[2] :
                          (fld(fn_high, POS_F2) == SEL_D) ? pa_sync[6] :
                          1'b1;
      serial_chip_select_in <=
        (fld(fn_low, POS_F1) == SEL_B) ? pa_sync[1] : 1'b1;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  a_high_rsvd_zero: assert property (
    avs_read && !ack && hit && ofs == OFS_SUP_HIGH
    |=> avs_readdata[7:6] == 2'h0 && avs_readdata[5:0] == $past(sup_high[5:0]))
    else $error("reserved supply bits not zero");

  a_aux_needs_pb4: assert property (
    !pb4_aux_supply_fn ##1 !pb4_aux_supply_fn |-> aux_supply_sel == 7'h00)
    else $error("aux supply without PB4 function");

  a_aux_pa6_field: assert property (
    pb4_aux_supply_fn && sup_low[7] |=> aux_supply_sel[3])
    else $error("PA6 aux supply not selected");

  a_drive_gated: assert property (
    pa_pad_oe_n[2] |-> pa_drive_level[5:4] == 2'h0)
    else $error("drive level on non-output pin");

  a_drive_pb_map: assert property (
    !pb_dir[4] |=> pb_drive_level[9:8] == $past(drv_ab[7:6]))
    else $error("PB4 drive level wrong field");

  a_drive_pd_map: assert property (
    !pd_dir[6] |=> pd_drive_level[13:12] == $past(drv_cd[7:6]))
    else $error("PD6 drive level wrong field");

  a_pa3_uart_tx: assert property (
    fn_low[7:6] == SEL_C |=> !pa_pad_oe_n[3]
    && pa_pad_out[3] == $past(uart0_transmit))
    else $error("PA3 not driven by uart0 transmit");

  a_pa1_analog: assert property (
    fn_low[3] |=> pa_pad_oe_n[1] && pa_analog_en[1])
    else $error("PA1 analog select not honoured");

  a_pa0_gpio_alias: assert property (
    fn_low[1:0] == SEL_D |=> pa_pad_oe_n[0] == $past(pa_dir[0])
    && pa_pad_out[0] == $past(pa_data[0]))
    else $error("PA0 code 11 not gpio");

  a_pa6_ptimer: assert property (
    fn_high[5:4] == SEL_B |=> pa_pad_out[6] == $past(periodic_timer0_out))
    else $error("PA6 not periodic timer0");

  a_int_dir_gate: assert property (
    !pa_dir[3] |=> !ext_interrupt_zero)
    else $error("interrupt passed on output pin");

  a_reset_values: assert property (
    $fell(rst) |-> pa_dir == RST_DIR && fn_low == RST_CFG
    && sup_low == RST_CFG && drv_ab == RST_CFG)
    else $error("wrong value after reset");

  a_bus_answer: assert property (
    (avs_read || avs_write) && avs_waitrequest ##1 (avs_read || avs_write)
    |-> !avs_waitrequest ##1 !ack)
    else $error("bus answer not in one wait cycle");

  c_uart_on_pa3: cover property (fn_low[7:6] == SEL_C ##1 !pa_pad_oe_n[3]);
  c_aux_active:  cover property (aux_supply_sel != 7'h00);
  c_max_drive:   cover property (pa_drive_level[1:0] == SEL_D);
  c_serial_in:   cover property (fn_high[5:4] == SEL_C ##1 !serial_data_in);

endmodule

// >>> ppf_periph_model.sv
`timescale 1ns/10ps
// far side: peripherals and the port A pads
module ppf_periph_model (
  input  wire logic       v,
  input  wire logic [7:0] pad_out,
  input  wire logic [7:0] pad_oe_n,
  input  wire logic [7:0] ext,
  output logic      [7:0] pad_in,
  output logic            p_out,
  output logic            p_oe_n
);
  // every peripheral drives the same level, always enabled
  assign p_out  = v;
  assign p_oe_n = 1'b0;
  // driven pads read back their own level, released ones the board level
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      pad_in[i] = pad_oe_n[i] ? ext[i] : pad_out[i];
    end
  end
endmodule

// >>> ppf_port_pin_function_config_bench.sv
`timescale 1ns/10ps
module ppf_port_pin_function_config_bench import ppf_pkg::*;;
  logic        clk, rst, avs_read, avs_write, pb4_aux_supply_fn, v;
  logic [5:0]  avs_address;
  logic [31:0] avs_writedata, avs_readdata;
  logic        avs_waitrequest, p_out, p_oe_n;
  logic [7:0]  pa_pad_in, pa_pad_out, pa_pad_oe_n, pa_analog_en, ext;
  logic [7:0]  pb_dir, pc_dir, q, eo, eoe, ean;
  logic [6:0]  pd_dir, aux_supply_sel;
  logic [15:0] pa_drive_level, pb_drive_level, pc_drive_level;
  logic [13:0] pd_drive_level;
  logic        ext_interrupt_zero, ext_interrupt_one, std_timer0_clock_in;
  logic        serial_clock_in, serial_data_in;
  logic [1:0]  k;
  int          fails, total_checks;
  // per pin, codes 3..0: 0 gpio, 1 digital peripheral, 2 analog
  logic [7:0]  kind [8] = '{8'h14, 8'hA4, 8'h54, 8'h94,
                            8'hA4, 8'h24, 8'h54, 8'hA4};
  logic [5:0]  ofs [7] = '{OFS_SUP_LOW, OFS_SUP_HIGH, OFS_DRV_AB, OFS_DRV_CD,
                           OFS_FN_LOW, OFS_FN_HIGH, OFS_PA_DIR};

  ppf_port_pin_function_config uut (
    .clk, .rst, .avs_address, .avs_read, .avs_write, .avs_writedata,
    .avs_byteenable(4'hF), .avs_readdata, .avs_waitrequest, .pa_pad_in,
    .pa_pad_out, .pa_pad_oe_n, .pa_analog_en, .pb_dir, .pc_dir, .pd_dir,
    .pb4_aux_supply_fn, .aux_supply_sel, .pa_drive_level, .pb_drive_level,
    .pc_drive_level, .pd_drive_level,
    .serial_clock_out(p_out), .serial_clock_oe_n(p_oe_n),
    .serial_chip_select_out(p_out), .serial_chip_select_oe_n(p_oe_n),
    .serial_data_io_out(p_out), .serial_data_io_oe_n(p_oe_n),
    .serial_data_out(p_out), .serial_data_out_oe_n(p_oe_n),
    .uart0_transmit(p_out), .uart0_receive_transmit(p_out),
    .uart0_rt_oe_n(p_oe_n), .periodic_timer0_out(p_out),
    .periodic_timer1_inverted_out(p_out),
    .periodic_timer2_inverted_out(p_out),
    .std_timer0_inverted_out(p_out), .std_timer1_inverted_out(p_out),
    .ext_interrupt_zero, .ext_interrupt_one, .std_timer1_capture_in(),
    .std_timer0_capture_in(), .periodic_timer0_capture_in(),
    .std_timer0_clock_in, .periodic_timer0_clock_in(), .serial_clock_in,
    .serial_data_in, .serial_chip_select_in(), .uart0_receive_in()
  );

  ppf_periph_model partner (
    .v, .pad_out(pa_pad_out), .pad_oe_n(pa_pad_oe_n), .ext,
    .pad_in(pa_pad_in), .p_out, .p_oe_n
  );

  // free-running 25 MHz clock
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  task automatic end_sim;
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      fails++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask

  // one avalon transfer; held until waitrequest is seen low at a rising
  // edge, read data taken at that edge; only the watchdog ends a hang
  task automatic bus(input logic w, input logic [5:0] a,
                     input logic [7:0] d);
    @(posedge clk);
    avs_address   <= a;
    avs_writedata <= {24'h000000, d};
    avs_write     <= w;
    avs_read      <= ~w;
    do begin
      @(posedge clk);
    end while (avs_waitrequest !== 1'b0);
    q = avs_readdata[7:0];
    avs_write <= 1'b0;
    avs_read  <= 1'b0;
  endtask

  task automatic wait_n(input int n);
    repeat (n) @(posedge clk);
    @(negedge clk);
  endtask

  // watchdog, well past the expected few hundred cycles
  initial begin
    repeat (20000) @(posedge clk);
    fails++;
    $display("mismatch watchdog expected done seen timeout");
    end_sim();
  end

  initial begin
    rst = 1'b1;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_address = 6'h00;
    avs_writedata = 32'h00000000;
    pb4_aux_supply_fn = 1'b0;
    v = 1'b0;
    ext = 8'h00;
    pb_dir = 8'hFF;
    pc_dir = 8'hFF;
    pd_dir = 7'h7F;
    fails = 0;
    total_checks = 0;
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    for (int i = 0; i < 7; i++) begin
      bus(1'b0, ofs[i], 8'h00);
      chk("reset value", (i == 6) ? RST_DIR : RST_CFG, q);
    end
    $display("test reset values done");
    // all ones written back, reserved supply bits must drop out
    for (int i = 0; i < 6; i++) begin
      bus(1'b1, ofs[i], 8'hFF);
      bus(1'b0, ofs[i], 8'h00);
      chk("readback", (i == 1) ? SUP_HIGH_MASK : 8'hFF, q);
    end
    bus(1'b1, 6'h24, 8'hFF);
    bus(1'b0, 6'h24, 8'h00);
    chk("unmapped", 32'h0, q);
    $display("test register access done");
    bus(1'b1, OFS_SUP_LOW, 8'hAA);
    bus(1'b1, OFS_SUP_HIGH, 8'h2A);
    wait_n(2);
    chk("aux without pb4", 32'h0, aux_supply_sel);
    @(posedge clk);
    pb4_aux_supply_fn <= 1'b1;
    wait_n(2);
    chk("aux all", 32'h7F, aux_supply_sel);
    bus(1'b1, OFS_SUP_LOW, 8'h80);
    wait_n(2);
    chk("aux pa6 only", 32'h78, aux_supply_sel);
    bus(1'b1, OFS_SUP_LOW, 8'h40);
    wait_n(2);
    chk("aux lower bit", 32'h70, aux_supply_sel);
    $display("test supply select done");
    @(posedge clk);
    pb_dir <= 8'h00;
    pc_dir <= 8'h00;
    pd_dir <= 7'h00;
    bus(1'b1, OFS_DRV_AB, 8'hE4);
    bus(1'b1, OFS_DRV_CD, 8'h1B);
    bus(1'b1, OFS_FN_LOW, 8'h00);
    bus(1'b1, OFS_FN_HIGH, 8'h00);
    bus(1'b1, OFS_PA_DIR, 8'h00);
    wait_n(2);
    chk("drive pa", 32'h5500, pa_drive_level);
    chk("drive pb", 32'hFFAA, pb_drive_level);
    chk("drive pc", 32'hAAFF, pc_drive_level);
    chk("drive pd", 32'h0055, pd_drive_level);
    @(posedge clk);
    pb_dir <= 8'hFF;
    pc_dir <= 8'hFF;
    pd_dir <= 7'h7F;
    bus(1'b1, OFS_PA_DIR, 8'hFF);
    wait_n(2);
    chk("drive inputs", 32'h0, {pa_drive_level | pb_drive_level,
        pc_drive_level | {2'b00, pd_drive_level}});
    $display("test drive level done");
    // both peripheral levels, so gpio and peripheral paths differ
    for (int vv = 0; vv < 2; vv++) begin
      for (int c = 0; c < 4; c++) begin
        @(posedge clk);
        v <= vv[0];
        bus(1'b1, OFS_PA_DATA, {8{~vv[0]}});
        bus(1'b1, OFS_PA_DIR, 8'h00);
        bus(1'b1, OFS_FN_LOW, {4{c[1:0]}});
        bus(1'b1, OFS_FN_HIGH, {4{c[1:0]}});
        wait_n(2);
        for (int p = 0; p < 8; p++) begin
          k = kind[p][2*c +: 2];
          eo[p] = (k == 2'h1) ? vv[0] : ~vv[0];
          eoe[p] = (k == 2'h2);
          ean[p] = (k == 2'h2);
        end
        chk("pad oe_n", eoe, pa_pad_oe_n);
        chk("analog en", ean, pa_analog_en);
        chk("pad out", eo | ean, pa_pad_out | ean);
      end
    end
    $display("test function mux done");
    bus(1'b1, OFS_FN_LOW, 8'h00);
    bus(1'b1, OFS_FN_HIGH, 8'h00);
    bus(1'b1, OFS_PA_DIR, 8'hFF);
    @(posedge clk);
    ext <= 8'hFF;
    wait_n(4);
    chk("inputs high", 32'hF, {ext_interrupt_zero, ext_interrupt_one,
        std_timer0_clock_in, serial_clock_in});
    @(posedge clk);
    ext <= 8'h00;
    wait_n(4);
    chk("inputs low", 32'h1, {ext_interrupt_zero, ext_interrupt_one,
        std_timer0_clock_in, serial_clock_in});
    @(posedge clk);
    ext <= 8'hFF;
    bus(1'b1, OFS_PA_DATA, 8'hFF);
    bus(1'b1, OFS_PA_DIR, 8'h00);
    wait_n(4);
    chk("inputs gated", 32'h1, {ext_interrupt_zero, ext_interrupt_one,
        std_timer0_clock_in, serial_clock_in});
    // serial clock and data in from PA0 and PA2, low so idle cannot pass
    @(posedge clk);
    v <= 1'b0;
    bus(1'b1, OFS_FN_LOW, 8'h11);
    wait_n(4);
    chk("serial inputs", 32'h0, {serial_clock_in, serial_data_in});
    $display("test input routing done");
    end_sim();
  end
endmodule
